// ==== hdl/ssc_device.sv ====
// slave-side serial channel with wishbone register file
//
// What this block does
// - without continuation, last frame clears channel enable
// - phase zero: shift even edges, sample odd
// - bit order zero sends MSB first
// - parity select zero means odd; check enable
// - software sets slave priority to 111
// - software leaves channel lock cleared
// - software sets clock polarity zero
// - software clears idle, select and safe controls
// - software keeps baud word at 0001
// - software sets setup, hold, idle delays 0001
// - software sets inter-data delay to 0000
// - software sets select and job-end 0000
// - software sets buffer size 00 direct mode
// - hardware trigger ignored unless selected
// - first-frame CRC error reported unless masked
// - interrupt enables let requests out
// - frame count setting gives frames per run
// - select input enable honours chip select pin
// - polarity zero means clock idles low
// - master/slave select one means slave mode
//
// Our own choices: the Wishbone register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module ssc_device (
  input wire logic mclk,
  input wire logic rst_n,
  ssc_link_if.dev link,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic hw_trigger,
  output logic irq_error,
  output logic irq_frame_end,
  output logic irq_rx,
  output logic irq_tx
);
  typedef struct packed {
    ssc_pkg::ssc_ctrl_t ctrl;
    ssc_pkg::ssc_fmt_t fmt;
    logic [15:0] baud, setup, hold, idle, inda, fcnt, ssel, left;
    logic [31:0] txd, rxd, tsh, rsh, dat;
    logic [5:0] cnt;
    logic [2:0] sck_q, cs_q, mo_q;
    logic sck_s, cs_s, mo_s;
    logic en, act, first, rx_full, perr, cerr, aerr;
    logic tpar, rpar, miso, moe, ack;
    logic ie, ife, irx, itx;
  } ssc_dev_st_t;

  localparam ssc_dev_st_t RST = '{
    ctrl: ssc_pkg::CTRL_RST,
    fmt: ssc_pkg::FMT_RST,
    baud: ssc_pkg::BAUD_RST,
    setup: ssc_pkg::DLY_RST,
    hold: ssc_pkg::DLY_RST,
    idle: ssc_pkg::DLY_RST,
    inda: ssc_pkg::INDA_RST,
    fcnt: ssc_pkg::FCNT_RST,
    ssel: ssc_pkg::SSEL_RST,
    cs_q: 3'h7,
    cs_s: 1'h1,
    default: '0
  };

  ssc_dev_st_t q, n;
  ssc_pkg::ssc_stat_t wc;
  logic [31:0] cur, w;
  logic [5:0] len, idx;
  logic acc, wr, sw_go, sw_stop, go, k_old, k_new, lead, trail, samp, shft;
  logic cs_act, cs_fall, live, lastb, bad_par;

  // only reports the slave set-up; a wrong set-up is not blocked
  function automatic logic cfg_fault(input ssc_dev_st_t s);
    return s.ctrl.master_slave_select & (
      (s.ctrl.channel_priority != ssc_pkg::PRIO_SLAVE) |
      s.ctrl.channel_lock |
      s.fmt.clock_polarity |
      s.fmt.forced_idle_after_frame | s.fmt.idle_select_level |
      s.fmt.select_return_inactive | s.fmt.safe_protocol_enable |
      (s.baud != ssc_pkg::BAUD_SLAVE) |
      (s.setup != ssc_pkg::DLY_SLAVE) | (s.hold != ssc_pkg::DLY_SLAVE) |
      (s.idle != ssc_pkg::DLY_SLAVE) |
      (s.inda != ssc_pkg::INDA_SLAVE) |
      (s.ssel != ssc_pkg::SSEL_SLAVE) |
      ((s.ctrl.memory_mode_select == ssc_pkg::MODE_DIRECT) &
       (s.fmt.buffer_size != ssc_pkg::SIZE_DIRECT)));
  endfunction

  function automatic logic [31:0] rd_word(input ssc_dev_st_t s, input logic [7:0] a);
    ssc_pkg::ssc_stat_t st;
    st = '0;
    st.channel_enable_flag = s.en;
    st.busy = s.act;
    st.rx_full = s.rx_full;
    st.abort_error = s.aerr;
    st.parity_error = s.perr;
    st.crc_error = s.cerr;
    st.config_fault = cfg_fault(s);
    case (a)
      ssc_pkg::ADR_CTRL: return s.ctrl;
      ssc_pkg::ADR_FMT: return s.fmt;
      ssc_pkg::ADR_BAUD: return {16'h0000, s.baud};
      ssc_pkg::ADR_SETUP: return {16'h0000, s.setup};
      ssc_pkg::ADR_HOLD: return {16'h0000, s.hold};
      ssc_pkg::ADR_IDLE: return {16'h0000, s.idle};
      ssc_pkg::ADR_INDA: return {16'h0000, s.inda};
      ssc_pkg::ADR_FCNT: return {16'h0000, s.fcnt};
      ssc_pkg::ADR_SSEL: return {16'h0000, s.ssel};
      ssc_pkg::ADR_TXD: return s.txd;
      ssc_pkg::ADR_RXD: return s.rxd;
      ssc_pkg::ADR_STAT: return st;
      default: return 32'h00000000;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // low byte must equal the xor of the upper three bytes
  function automatic logic check_ok(input logic [31:0] d);
    return d[7:0] == (d[31:24] ^ d[23:16] ^ d[15:8]);
  endfunction

  always_comb begin
    n = q;
    cur = rd_word(q, wb_adr_i);
    w = merge(cur, wb_dat_i, wb_sel_i);
    wc = w;
    acc = wb_cyc_i & wb_stb_i & ~q.ack;
    wr = wb_cyc_i & wb_stb_i & wb_we_i & q.ack; // lands at the edge where the master sees ack
    sw_go = wr & (wb_adr_i == ssc_pkg::ADR_TRIG) & w[ssc_pkg::TRIG_START];
    sw_stop = wr & (wb_adr_i == ssc_pkg::ADR_TRIG) & w[ssc_pkg::TRIG_STOP];
    n.ack = acc;
    if (acc) begin
      n.dat = cur;
    end
    n.ie = 1'h0;
    n.ife = 1'h0;
    n.irx = 1'h0;
    n.itx = 1'h0;
    // first stage feeds only the second; a level counts once stages two and three agree
    n.sck_q = {q.sck_q[1:0], link.sclk};
    n.cs_q = {q.cs_q[1:0], link.cs_n};
    n.mo_q = {q.mo_q[1:0], link.mosi};
    if (q.sck_q[2] == q.sck_q[1]) begin
      n.sck_s = q.sck_q[2];
    end
    if (q.cs_q[2] == q.cs_q[1]) begin
      n.cs_s = q.cs_q[2];
    end
    if (q.mo_q[2] == q.mo_q[1]) begin
      n.mo_s = q.mo_q[2];
    end
    k_old = q.sck_s ^ q.fmt.clock_polarity;
    k_new = n.sck_s ^ q.fmt.clock_polarity;
    lead = ~k_old & k_new;
    trail = k_old & ~k_new;
    samp = q.fmt.clock_phase ? trail : lead;
    shft = q.fmt.clock_phase ? lead : trail;
    cs_act = q.ctrl.select_input_enable ? ~n.cs_s : 1'h1;
    cs_fall = q.cs_s & ~n.cs_s;
    live = q.en & q.ctrl.master_slave_select;
    len = q.fmt.frame_length;
    idx = q.fmt.clock_phase ? q.cnt : 6'(q.cnt + 6'h01);
    lastb = (q.cnt == len);
    bad_par = q.rpar ^ n.mo_s ^ ~q.fmt.parity_select;
    go = q.ctrl.hw_trigger_select ? hw_trigger : sw_go;

    if (wr) begin
      case (wb_adr_i)
        ssc_pkg::ADR_CTRL: begin
          n.ctrl = w;
          n.ctrl.rsvd = '0;
        end
        ssc_pkg::ADR_FMT: begin
          n.fmt = w;
          n.fmt.rsvd = '0;
        end
        ssc_pkg::ADR_BAUD: n.baud = w[15:0];
        ssc_pkg::ADR_SETUP: n.setup = w[15:0];
        ssc_pkg::ADR_HOLD: n.hold = w[15:0];
        ssc_pkg::ADR_IDLE: n.idle = w[15:0];
        ssc_pkg::ADR_INDA: n.inda = w[15:0];
        ssc_pkg::ADR_FCNT: n.fcnt = w[15:0];
        ssc_pkg::ADR_SSEL: n.ssel = w[15:0];
        ssc_pkg::ADR_TXD: n.txd = w;
        ssc_pkg::ADR_STAT: begin
          n.perr = q.perr & ~wc.parity_error;
          n.cerr = q.cerr & ~wc.crc_error;
          n.aerr = q.aerr & ~wc.abort_error;
        end
        default: ;
      endcase
    end
    if (acc & ~wb_we_i & (wb_adr_i == ssc_pkg::ADR_RXD)) begin
      n.rx_full = 1'h0;
    end
    if (sw_stop) begin
      n.en = 1'h0;
    end else if (go & ~q.en) begin
      n.en = 1'h1;
      n.left = q.fcnt;
      n.first = 1'h1;
    end

    // hardware sets below override software clears above
    if (q.act & (~live | ~cs_act)) begin
      n.act = 1'h0;
      n.moe = 1'h0;
      n.aerr = 1'h1;
      n.ie = q.ctrl.error_irq_enable;
    end else if (~q.act) begin
      // with the select pin in use a frame needs a fresh falling select
      if (live & cs_act & (cs_fall | ~q.ctrl.select_input_enable)) begin
        n.act = 1'h1;
        n.cnt = 6'h00;
        n.tsh = q.txd;
        n.rsh = 32'h00000000;
        n.rpar = 1'h0;
        n.tpar = ssc_pkg::data_parity(q.txd, len) ^ ~q.fmt.parity_select;
        n.moe = q.ctrl.tx_enable;
        n.itx = q.ctrl.tx_irq_enable;
        if (~q.fmt.clock_phase) begin
          n.miso = ssc_pkg::frame_bit(q.txd, 6'h00, len, q.fmt.bit_order, n.tpar);
        end
      end
    end else begin
      if (shft) begin
        n.miso = ssc_pkg::frame_bit(q.tsh, idx, len, q.fmt.bit_order, q.tpar);
        if (~q.fmt.clock_phase) begin
          n.cnt = idx;
        end
      end
      if (samp & ~lastb) begin
        n.rsh[5'(ssc_pkg::bit_pos(q.cnt, len, q.fmt.bit_order))] = n.mo_s;
        n.rpar = q.rpar ^ n.mo_s;
        if (q.fmt.clock_phase) begin
          n.cnt = 6'(q.cnt + 6'h01);
        end
      end else if (samp) begin
        n.act = 1'h0;
        n.moe = 1'h0;
        n.first = 1'h0;
        n.ife = q.ctrl.frame_end_irq_enable;
        if (q.ctrl.rx_enable) begin
          n.rxd = q.rsh;
          n.rx_full = 1'h1;
          n.irx = q.ctrl.rx_irq_enable;
        end
        if (q.fmt.parity_check_enable & bad_par) begin
          n.perr = 1'h1;
          n.ie = q.ctrl.error_irq_enable;
        end
        if (q.fmt.safe_protocol_enable & ~check_ok(q.rsh) &
            ~(q.first & q.fmt.first_frame_crc_mask)) begin
          n.cerr = 1'h1;
          n.ie = q.ctrl.error_irq_enable;
        end
        if (q.left > 16'h0001) begin
          n.left = 16'(q.left - 16'h0001);
        end else if (q.ctrl.frame_count_continue) begin
          n.left = q.fcnt;
        end else begin
          n.en = 1'h0;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      q <= RST;
    end else begin
      q <= n;
    end
  end

  assign wb_dat_o = q.dat;
  assign wb_ack_o = q.ack;
  assign link.miso = q.miso;
  assign link.miso_oe = q.moe;
  assign irq_error = q.ie;
  assign irq_frame_end = q.ife;
  assign irq_rx = q.irx;
  assign irq_tx = q.itx;
endmodule
`default_nettype wire

// ==== hdl/ssc_link_if.sv ====
// serial link between the channel and the external master
`timescale 1ns/10ps
`default_nettype none
interface ssc_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  modport dev (input sclk, input cs_n, input mosi, output miso, output miso_oe);
  modport mst (output sclk, output cs_n, output mosi, input miso, input miso_oe);
endinterface
`default_nettype wire

// ==== hdl/ssc_master.sv ====
// external master end: drives clock and select, one frame per start
`timescale 1ns/10ps
`default_nettype none
module ssc_master (
  input wire logic mclk,
  input wire logic rst_n,
  ssc_link_if.mst link,
  input wire logic start,
  input wire logic [31:0] tx_data,
  input wire logic [5:0] frame_length,
  input wire logic bit_order,
  input wire logic parity_select,
  output logic busy,
  output logic done,
  output logic [31:0] rx_data,
  output logic parity_ok
);
  typedef struct packed {
    ssc_pkg::ssc_mst_st_t st;
    logic [4:0] div;
    logic [5:0] cnt, len;
    logic [31:0] tsh, rsh, rxd;
    logic [2:0] mq;
    logic ms, ord, ps, tpar, rpar, sclk, cs_n, mosi, busy, done, pok;
  } ssc_mst_t;

  localparam ssc_mst_t RST = '{st: ssc_pkg::M_IDLE, cs_n: 1'h1, default: '0};

  ssc_mst_t q, n;
  logic tick;

  always_comb begin
    n = q;
    n.done = 1'h0;
    n.mq = {q.mq[1:0], link.miso & link.miso_oe};
    if (q.mq[2] == q.mq[1]) begin
      n.ms = q.mq[2];
    end
    tick = (q.div == ssc_pkg::HALF_LAST);
    n.div = tick ? 5'h00 : 5'(q.div + 5'h01);
    case (q.st)
      ssc_pkg::M_IDLE: begin
        n.div = 5'h00;
        n.sclk = 1'h0;
        n.cs_n = 1'h1;
        if (start) begin
          n.tsh = tx_data;
          n.len = frame_length;
          n.ord = bit_order;
          n.ps = parity_select;
          n.tpar = ssc_pkg::data_parity(tx_data, frame_length) ^ ~parity_select;
          n.mosi = ssc_pkg::frame_bit(tx_data, 6'h00, frame_length, bit_order, n.tpar);
          n.cnt = 6'h00;
          n.rsh = 32'h00000000;
          n.rpar = 1'h0;
          n.cs_n = 1'h0;
          n.busy = 1'h1;
          n.st = ssc_pkg::M_SETUP;
        end
      end
      ssc_pkg::M_SETUP, ssc_pkg::M_LOW: begin
        if (tick) begin
          n.sclk = 1'h1;
          n.st = ssc_pkg::M_HIGH;
        end
      end
      ssc_pkg::M_HIGH: begin
        // sampled late in the high phase to absorb the slave's sync delay
        if (tick) begin
          n.sclk = 1'h0;
          if (q.cnt < q.len) begin
            n.rsh[5'(ssc_pkg::bit_pos(q.cnt, q.len, q.ord))] = q.ms;
            n.rpar = q.rpar ^ q.ms;
            n.cnt = 6'(q.cnt + 6'h01);
            n.mosi = ssc_pkg::frame_bit(q.tsh, n.cnt, q.len, q.ord, q.tpar);
            n.st = ssc_pkg::M_LOW;
          end else begin
            n.rxd = q.rsh;
            n.pok = ~(q.rpar ^ q.ms ^ ~q.ps);
            n.st = ssc_pkg::M_HOLD;
          end
        end
      end
      ssc_pkg::M_HOLD: begin
        if (tick) begin
          n.cs_n = 1'h1;
          n.st = ssc_pkg::M_GAP;
        end
      end
      ssc_pkg::M_GAP: begin
        if (tick) begin
          n.busy = 1'h0;
          n.done = 1'h1;
          n.st = ssc_pkg::M_IDLE;
        end
      end
      default: n.st = ssc_pkg::M_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      q <= RST;
    end else begin
      q <= n;
    end
  end

  assign link.sclk = q.sclk;
  assign link.cs_n = q.cs_n;
  assign link.mosi = q.mosi;
  assign busy = q.busy;
  assign done = q.done;
  assign rx_data = q.rxd;
  assign parity_ok = q.pok;
endmodule
`default_nettype wire

// ==== hdl/ssc_pkg.sv ====
// shared constants, register layouts and helpers for the serial channel
package ssc_pkg;
  localparam int MCLK_MHZ = 50;
  localparam int SCLK_HALF_NS = 160;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * MCLK_MHZ + 999) / 1000;
  localparam logic [4:0] HALF_LAST = 5'(SCLK_HALF_CYC - 1);

  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_FMT = 8'h04;
  localparam logic [7:0] ADR_BAUD = 8'h08;
  localparam logic [7:0] ADR_SETUP = 8'h0C;
  localparam logic [7:0] ADR_HOLD = 8'h10;
  localparam logic [7:0] ADR_IDLE = 8'h14;
  localparam logic [7:0] ADR_INDA = 8'h18;
  localparam logic [7:0] ADR_FCNT = 8'h1C;
  localparam logic [7:0] ADR_SSEL = 8'h20;
  localparam logic [7:0] ADR_TRIG = 8'h24;
  localparam logic [7:0] ADR_TXD = 8'h28;
  localparam logic [7:0] ADR_RXD = 8'h2C;
  localparam logic [7:0] ADR_STAT = 8'h30;
  localparam int TRIG_START = 0;
  localparam int TRIG_STOP = 1;

  typedef struct packed {
    logic [16:0] rsvd;
    logic hw_trigger_select;
    logic select_input_enable;
    logic master_slave_select;
    logic tx_irq_enable;
    logic rx_irq_enable;
    logic frame_end_irq_enable;
    logic error_irq_enable;
    logic frame_count_continue;
    logic channel_lock;
    logic [2:0] channel_priority;
    logic memory_mode_select;
    logic rx_enable;
    logic tx_enable;
  } ssc_ctrl_t;

  typedef struct packed {
    logic [12:0] rsvd;
    logic [1:0] buffer_size;
    logic [5:0] frame_length;
    logic parity_check_enable;
    logic parity_select;
    logic safe_protocol_enable;
    logic safe_format_select;
    logic first_frame_crc_mask;
    logic select_return_inactive;
    logic forced_idle_after_frame;
    logic idle_select_level;
    logic bit_order;
    logic clock_phase;
    logic clock_polarity;
  } ssc_fmt_t;

  typedef struct packed {
    logic [24:0] rsvd;
    logic config_fault;
    logic crc_error;
    logic parity_error;
    logic abort_error;
    logic rx_full;
    logic busy;
    logic channel_enable_flag;
  } ssc_stat_t;

  localparam ssc_ctrl_t CTRL_RST = '{channel_priority: 3'h7, default: '0};
  localparam ssc_fmt_t FMT_RST = '{frame_length: 6'h20, default: '0};
  localparam logic [15:0] BAUD_RST = 16'h0001;
  localparam logic [15:0] DLY_RST = 16'h0001;
  localparam logic [15:0] INDA_RST = 16'h0000;
  localparam logic [15:0] SSEL_RST = 16'h0000;
  localparam logic [15:0] FCNT_RST = 16'h0001;
  localparam logic [2:0] PRIO_SLAVE = 3'h7;
  localparam logic [15:0] BAUD_SLAVE = 16'h0001;
  localparam logic [15:0] DLY_SLAVE = 16'h0001;
  localparam logic [15:0] INDA_SLAVE = 16'h0000;
  localparam logic [15:0] SSEL_SLAVE = 16'h0000;
  localparam logic [1:0] SIZE_DIRECT = 2'h0;
  localparam logic MODE_DIRECT = 1'h0;

  typedef enum logic [2:0] {
    M_IDLE = 3'h0,
    M_SETUP = 3'h1,
    M_HIGH = 3'h2,
    M_LOW = 3'h3,
    M_HOLD = 3'h4,
    M_GAP = 3'h5
  } ssc_mst_st_t;

  function automatic logic [5:0] bit_pos(input logic [5:0] idx, input logic [5:0] len,
                                         input logic lsb_first);
    return lsb_first ? idx : 6'(len - idx - 6'h01);
  endfunction

  function automatic logic data_parity(input logic [31:0] d, input logic [5:0] len);
    logic p;
    p = 1'h0;
    for (int i = 0; i < 32; i++) begin
      p = p ^ (d[i] & (6'(i) < len));
    end
    return p;
  endfunction

  // bits past the data length carry the parity bit
  function automatic logic frame_bit(input logic [31:0] d, input logic [5:0] idx,
                                     input logic [5:0] len, input logic lsb_first,
                                     input logic par);
    if (idx < len) begin
      return d[5'(bit_pos(idx, len, lsb_first))];
    end
    return par;
  endfunction
endpackage

// ==== verif/ssc_link_properties.sv ====
// link checker: timing relations between the two ends of the serial link
`timescale 1ns/10ps
`default_nettype none
module ssc_link_properties (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_OE_RISE_SELECTED: assert property ($rose(miso_oe) |-> !cs_n && !sclk)
    else $error("slave drive began outside select or with clock high");
  AST_OE_DROP_DESELECT: assert property ($rose(cs_n) |-> ##[0:6] !miso_oe)
    else $error("slave still driving after deselect");
  AST_SCLK_IDLE_LOW: assert property (cs_n |-> !sclk)
    else $error("serial clock high while deselected");
  AST_SCLK_AFTER_SELECT: assert property ($rose(sclk) |-> !cs_n && !$past(cs_n, 7))
    else $error("serial clock pulse without settled select");
  AST_MISO_STABLE_HIGH: assert property (sclk && $past(sclk) && miso_oe && $past(miso_oe) |-> $stable(miso))
    else $error("slave data moved while clock high");
  AST_MISO_MOVES_LOW: assert property (miso_oe && $past(miso_oe) && $changed(miso) |-> !sclk && !$past(sclk, 2))
    else $error("slave data moved outside the low phase");
  AST_MOSI_STABLE_HIGH: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("master data moved while clock high");
  AST_CLOCK_SETUP: assert property ($fell(cs_n) |-> (!sclk) [*7])
    else $error("clock left idle too soon after select");
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// self-checking bench: device and master facing each other on one link
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam logic [31:0] CT = 32'h00003F3B;
  localparam logic [31:0] FM = 32'h00010000;
  logic mclk, rst_n, cyc, stb, we, ack, hw_trig;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [3:0] sel;
  logic i_err, i_fe, i_rx, i_tx;
  logic m_start, m_ord, m_ps, m_done, m_pok;
  logic [31:0] m_tx, m_rx;
  logic [5:0] m_len;
  int n_mismatch, n_tests, n_cyc, c_fe, c_rx, c_tx, c_err;
  // address, expected reset value
  logic [7:0] ra [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h30};
  logic [31:0] rv [10] = '{32'h38, FM, 32'h1, 32'h1, 32'h1, 32'h1, 32'h0, 32'h1, 32'h0, 32'h0};
  // one bad software setting each, then its good value
  logic [7:0] ba [10] = '{8'h00, 8'h00, 8'h04, 8'h04, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h18, 8'h20};
  logic [31:0] bv [10] = '{CT & ~32'h8, CT | 32'h40, FM | 32'h1, FM | 32'h10, FM | 32'h20000,
                            32'h2, 32'h2, 32'h0, 32'h1, 32'h1};
  logic [31:0] gv [10] = '{CT, CT, FM, FM, FM, 32'h1, 32'h1, 32'h1, 32'h0, 32'h0};

  ssc_link_if ssc_link_if_inst();
  ssc_device ssc_device_inst (.mclk(mclk), .rst_n(rst_n), .link(ssc_link_if_inst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .hw_trigger(hw_trig),
    .irq_error(i_err), .irq_frame_end(i_fe), .irq_rx(i_rx), .irq_tx(i_tx));
  ssc_master ssc_master_inst (.mclk(mclk), .rst_n(rst_n), .link(ssc_link_if_inst),
    .start(m_start), .tx_data(m_tx), .frame_length(m_len), .bit_order(m_ord),
    .parity_select(m_ps), .busy(), .done(m_done), .rx_data(m_rx), .parity_ok(m_pok));
  ssc_link_properties ssc_link_properties_inst (.mclk(mclk), .rst_n(rst_n),
    .sclk(ssc_link_if_inst.sclk), .cs_n(ssc_link_if_inst.cs_n), .mosi(ssc_link_if_inst.mosi),
    .miso(ssc_link_if_inst.miso), .miso_oe(ssc_link_if_inst.miso_oe));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic give_verdict();
    $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // classic wishbone cycle; entered and left just after a rising edge
  // request stands until the rising edge that samples ack; only the bench timeout ends a hang
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge mclk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask

  // one frame from the master end; waits for its done pulse
  task automatic xfer(input logic [31:0] d, input logic [5:0] l, input logic o, input logic p);
    m_tx <= d;
    m_len <= l;
    m_ord <= o;
    m_ps <= p;
    m_start <= 1'b1;
    @(posedge mclk);
    m_start <= 1'b0;
    do begin
      @(posedge mclk);
    end while (m_done !== 1'b1);
    repeat (6) @(posedge mclk);
  endtask

  always @(posedge mclk) begin
    n_cyc <= n_cyc + 1;
    if (i_fe === 1'b1) c_fe++;
    if (i_rx === 1'b1) c_rx++;
    if (i_tx === 1'b1) c_tx++;
    if (i_err === 1'b1) c_err++;
    // whole run is seven frames, five of some 550 cycles each and two of some 160
    if (n_cyc == 40000) begin
      n_mismatch++;
      $display("FAIL %0t run did not finish", $time);
      give_verdict();
    end
  end

  initial begin
    {rst_n, cyc, stb, we, hw_trig, m_start, m_ord, m_ps} <= '0;
    {adr, wdat, m_tx} <= '0;
    sel <= 4'hF;
    m_len <= 6'h20;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 10; i++) rc(ra[i], 32'hFFFFFFFF, rv[i]);
    wb(1'b1, 8'h3C, 32'h5A5A5A5A);
    rc(8'h3C, 32'hFFFFFFFF, 32'h0);
    wb(1'b1, ssc_pkg::ADR_CTRL, CT);
    hw_trig <= 1'b1;
    @(posedge mclk);
    hw_trig <= 1'b0;
    rc(ssc_pkg::ADR_STAT, 32'h1, 32'h0);
    for (int i = 0; i < 10; i++) begin
      wb(1'b1, ba[i], bv[i]);
      rc(ssc_pkg::ADR_STAT, 32'h40, 32'h40);
      wb(1'b1, ba[i], gv[i]);
      rc(ssc_pkg::ADR_STAT, 32'h40, 32'h0);
    end
    // two-frame run, msb first, odd parity
    wb(1'b1, ssc_pkg::ADR_FCNT, 32'h2);
    wb(1'b1, ssc_pkg::ADR_TXD, 32'hA5C31E77);
    wb(1'b1, ssc_pkg::ADR_TRIG, 32'h1);
    xfer(32'h12345678, 6'h20, 1'b0, 1'b0);
    chk(m_rx, 32'hA5C31E77);
    chk({31'h0, m_pok}, 32'h1);
    rc(ssc_pkg::ADR_RXD, 32'hFFFFFFFF, 32'h12345678);
    chk(32'(c_tx + c_rx + c_fe), 32'h3);
    rc(ssc_pkg::ADR_STAT, 32'h1, 32'h1);
    wb(1'b1, ssc_pkg::ADR_TXD, 32'h0F0F00F1);
    xfer(32'h80000001, 6'h20, 1'b0, 1'b0);
    chk(m_rx, 32'h0F0F00F1);
    rc(ssc_pkg::ADR_STAT, 32'h1, 32'h0);
    // channel now off: a further frame gets no answer
    xfer(32'hFFFFFFFF, 6'h20, 1'b0, 1'b0);
    chk(32'(c_rx), 32'h2);
    rc(ssc_pkg::ADR_RXD, 32'hFFFFFFFF, 32'h80000001);
    // master mode selected: link traffic is not taken
    wb(1'b1, ssc_pkg::ADR_CTRL, CT & ~32'h1000);
    wb(1'b1, ssc_pkg::ADR_TRIG, 32'h1);
    xfer(32'h00000055, 6'h20, 1'b0, 1'b0);
    chk(32'(c_rx), 32'h2);
    wb(1'b1, ssc_pkg::ADR_TRIG, 32'h2);
    // only the error interrupt left on, 8-bit lsb first, master sends even parity
    wb(1'b1, ssc_pkg::ADR_CTRL, CT & ~32'hE00);
    wb(1'b1, ssc_pkg::ADR_FMT, 32'h00004404);
    wb(1'b1, ssc_pkg::ADR_FCNT, 32'h1);
    wb(1'b1, ssc_pkg::ADR_TXD, 32'h000000C5);
    wb(1'b1, ssc_pkg::ADR_TRIG, 32'h1);
    xfer(32'h0000003A, 6'h08, 1'b1, 1'b1);
    chk(m_rx & 32'hFF, 32'hC5);
    chk({31'h0, m_pok}, 32'h0);
    rc(ssc_pkg::ADR_RXD, 32'hFF, 32'h3A);
    rc(ssc_pkg::ADR_STAT, 32'h11, 32'h10);
    chk(32'(c_rx + c_fe), 32'h4);
    chk(32'(c_err), 32'h1);
    // parity check off: the same frame raises no error
    wb(1'b1, ssc_pkg::ADR_STAT, 32'h10);
    wb(1'b1, ssc_pkg::ADR_FMT, 32'h00004004);
    wb(1'b1, ssc_pkg::ADR_TRIG, 32'h1);
    xfer(32'h0000003A, 6'h08, 1'b1, 1'b1);
    rc(ssc_pkg::ADR_STAT, 32'h10, 32'h0);
    // first frame failing its check byte is reported, not masked
    wb(1'b1, ssc_pkg::ADR_FMT, FM | 32'h100);
    wb(1'b1, ssc_pkg::ADR_TRIG, 32'h1);
    xfer(32'h00000001, 6'h20, 1'b0, 1'b0);
    rc(ssc_pkg::ADR_STAT, 32'h20, 32'h20);
    chk(32'(c_err), 32'h2);
    give_verdict();
  end
endmodule
`default_nettype wire
